// [hdl/pcdld_pkg.sv]
`default_nettype none
package pcdld_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and field widths.
  localparam int CLK_PERIOD_PS = 40000;
  localparam int REF_DIV_W     = 10;
  localparam int FB_DIV_W      = 12;
  localparam int NUM_PAIRS     = 5;
  localparam int CNT_W         = 16;

  ////////////////////////////////////////////////////////////////////////////////
  // Register word offsets (byte addresses).
  localparam logic [7:0] ADDR_CFG0     = 8'h00;
  localparam logic [7:0] ADDR_CFG1     = 8'h04;
  localparam logic [7:0] ADDR_CFG2     = 8'h08;
  localparam logic [7:0] ADDR_CFG3     = 8'h0C;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

  // Field positions inside the configuration words.
  localparam int CFG0_FB_LSB    = 10;
  localparam int CFG0_RDLY_LSB  = 22;
  localparam int CFG0_FDLY_LSB  = 25;
  localparam int CFG1_MODE_LSB  = 5;
  localparam int CFG2_PUMP_LSB  = 2;
  localparam int CFG3_CNT_LSB   = 2;

  // Interrupt status bit positions.
  localparam int IRQ_GAINED = 0;
  localparam int IRQ_LOST   = 1;
  localparam int IRQ_FREQ   = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic [REF_DIV_W-1:0] REF_DIV_RST  = 10'h07F;
  localparam logic [FB_DIV_W-1:0]  FB_DIV_RST   = 12'h07F;
  localparam logic [NUM_PAIRS-1:0] PAIR_SEL_RST = 5'h1F;
  localparam logic [1:0]           PW_RST       = 2'h0;
  localparam logic [3:0]           PUMP_RST     = 4'hA;
  localparam logic [1:0]           WIN_RST      = 2'h1;
  localparam logic [1:0]           CNT_RST      = 2'h2;
  localparam logic [1:0]           WIN_FREQ     = 2'h3;
  localparam logic [11:0]          PUMP_STEP_UA = 12'h0C8;

  ////////////////////////////////////////////////////////////////////////////////
  // Times in picoseconds and their cycle counts.
  localparam int WIN0_PS   = 3500;
  localparam int WIN1_PS   = 8500;
  localparam int WIN2_PS   = 18500;
  localparam int PW0_PS    = 1500;
  localparam int PW1_PS    = 3000;
  localparam int PW2_PS    = 4500;
  localparam int PW3_PS    = 6000;
  // Windows are longest times, so they round down, never below one cycle.
  localparam int WIN0_CYC = (WIN0_PS / CLK_PERIOD_PS) < 1 ? 1 : WIN0_PS / CLK_PERIOD_PS;
  localparam int WIN1_CYC = (WIN1_PS / CLK_PERIOD_PS) < 1 ? 1 : WIN1_PS / CLK_PERIOD_PS;
  localparam int WIN2_CYC = (WIN2_PS / CLK_PERIOD_PS) < 1 ? 1 : WIN2_PS / CLK_PERIOD_PS;
  // Pulse widths are least times, so they round up.
  localparam int PW0_CYC = (PW0_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PW1_CYC = (PW1_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PW2_CYC = (PW2_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PW3_CYC = (PW3_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [8:0] LOCK_CNT_MAX = 9'h100;

  ////////////////////////////////////////////////////////////////////////////////
  // Decoded analog settings handed to the loop.
  typedef struct packed {
    logic [10:0] refDelayPs;
    logic [10:0] fbDelayPs;
    logic [12:0] pulseWidthPs;
    logic [11:0] pumpCurrentUa;
    logic        pumpHighZ;
  } pcdld_analog_type;

  // Whole state of the block.
  typedef struct packed {
    logic [REF_DIV_W-1:0]      refDiv;
    logic [FB_DIV_W-1:0]       fbDiv;
    logic [2:0]                refDly;
    logic [2:0]                fbDly;
    logic [NUM_PAIRS-1:0]      pairSel;
    logic [NUM_PAIRS-1:0][1:0] modeA;
    logic [NUM_PAIRS-1:0][1:0] modeB;
    logic [1:0]                pwCode;
    logic [3:0]                pumpCode;
    logic [1:0]                winCode;
    logic [1:0]                cntCode;
    logic                      refPrev;
    logic                      fbPrev;
    logic [REF_DIV_W-1:0]      refCnt;
    logic [FB_DIV_W-1:0]       fbCnt;
    logic [CNT_W-1:0]          phaseCnt;
    logic                      pendRef;
    logic                      pendFb;
    logic [CNT_W-1:0]          refPerCnt;
    logic [CNT_W-1:0]          fbPerCnt;
    logic [CNT_W-1:0]          refPer;
    logic [CNT_W-1:0]          fbPer;
    logic [8:0]                lockCnt;
    logic                      locked;
    logic                      inWin;
    logic [2:0]                irqStat;
    logic [2:0]                irqMask;
    logic                      irq;
    logic                      ack;
    logic [31:0]               rdData;
    logic [NUM_PAIRS-1:0]      outA;
    logic [NUM_PAIRS-1:0]      outAOeN;
    logic [NUM_PAIRS-1:0]      outB;
    logic [NUM_PAIRS-1:0]      outBOeN;
    pcdld_analog_type          analog;
  } pcdld_state_type;

  ////////////////////////////////////////////////////////////////////////////////
  // Phase offset in ps for a 3-bit delay code.
  function automatic logic [10:0] delayPs(input logic [2:0] code);
    unique case (code)
      3'h0: delayPs = 11'h000;
      3'h1: delayPs = 11'h0A0;
      3'h2: delayPs = 11'h140;
      3'h3: delayPs = 11'h1E0;
      3'h4: delayPs = 11'h33E;
      3'h5: delayPs = 11'h46A;
      3'h6: delayPs = 11'h5AA;
      3'h7: delayPs = 11'h6D6;
    endcase
  endfunction

  // Detector pulse width in ps for a 2-bit code.
  function automatic logic [12:0] pulsePs(input logic [1:0] code);
    unique case (code)
      2'h0: pulsePs = 13'(PW0_PS);
      2'h1: pulsePs = 13'(PW1_PS);
      2'h2: pulsePs = 13'(PW2_PS);
      2'h3: pulsePs = 13'(PW3_PS);
    endcase
  endfunction

  // Charge pump current in uA, zero for the high-impedance code.
  function automatic logic [11:0] pumpUa(input logic [3:0] code);
    pumpUa = 12'({8'h00, code} * PUMP_STEP_UA);
  endfunction

endpackage
`default_nettype wire

// [hdl/pcdld_top.sv]
// Notes on behaviour
// - Reference divided by 10-bit code plus one, 1 to 1024, default 128.
// - Feedback divided by 12-bit code plus one, 1 to 4096, default 128.
// - Single-ended half: 00 clock, 01 high impedance, 10 inverted, 11 low.
// - Differential pair: only A-half low bit counts, 0 drives, 1 high impedance.
// - Delay codes pick 0 to 1750 ps offsets; both default to zero.
// - Reference delay makes outputs lag; feedback delay makes them lead.
// - Pulse-width code picks 1.5, 3, 4.5 or 6 ns; default 1.5 ns.
// - Window code picks 3.5, 8.5 or 18.5 ns, or frequency detection.
// - Frequency mode drops lock whenever reference and feedback frequencies differ.
// - Smallest detected offset follows from detector period plus pulse width.
// - Lock rises after 1, 16, 64 or 256 successive in-window comparisons.
// - Lock falls at the first out-of-window comparison, with no count.
// - Pump code 0 is high impedance, then 200 uA steps to 3 mA.
//
// Added by the designer: the register addresses and register access over Wishbone.
`default_nettype none
module pcdld_top (
  input  wire logic                       mclk,
  input  wire logic                       resetn,
  input  wire logic                       wbCyc,
  input  wire logic                       wbStb,
  input  wire logic                       wbWe,
  input  wire logic [7:0]                 wbAdr,
  input  wire logic [3:0]                 wbSel,
  input  wire logic [31:0]                wbDatIn,
  output      logic [31:0]                wbDatOut,
  output      logic                       wbAck,
  output      logic                       irq,
  input  wire logic                       refClkIn,
  input  wire logic                       fbClkIn,
  input  wire logic                       vcoClkIn,
  output      logic [pcdld_pkg::NUM_PAIRS-1:0] halfAOut,
  output      logic [pcdld_pkg::NUM_PAIRS-1:0] halfAOeN,
  output      logic [pcdld_pkg::NUM_PAIRS-1:0] halfBOut,
  output      logic [pcdld_pkg::NUM_PAIRS-1:0] halfBOeN,
  output      logic                       pllLock,
  output      logic                       lockInWindow,
  output      pcdld_pkg::pcdld_analog_type analogCfg
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Drive of one single-ended half: returns {enableN, value}.
  function automatic logic [1:0] halfDrive(input logic [1:0] mode, input logic clk);
    unique case (mode)
      2'h0: halfDrive = {1'b0, clk};
      2'h1: halfDrive = {1'b1, 1'b0};
      2'h2: halfDrive = {1'b0, ~clk};
      2'h3: halfDrive = {1'b0, 1'b0};
    endcase
  endfunction

  // Saturating increment of a measurement counter.
  function automatic logic [pcdld_pkg::CNT_W-1:0] satInc(
    input logic [pcdld_pkg::CNT_W-1:0] v
  );
    satInc = (&v) ? v : v + 1'b1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State.
  pcdld_pkg::pcdld_state_type s_reg;
  pcdld_pkg::pcdld_state_type s_next;

  logic [pcdld_pkg::CNT_W-1:0] winCyc;
  logic [pcdld_pkg::CNT_W-1:0] pwCyc;
  logic [8:0]                  cntTarget;

  // Window and pulse width in clock cycles, and the successive-event target.
  always_comb begin
    unique case (s_reg.winCode)
      2'h0: winCyc = 16'(pcdld_pkg::WIN0_CYC);
      2'h1: winCyc = 16'(pcdld_pkg::WIN1_CYC);
      2'h2: winCyc = 16'(pcdld_pkg::WIN2_CYC);
      2'h3: winCyc = 16'(pcdld_pkg::WIN2_CYC);
    endcase
    unique case (s_reg.pwCode)
      2'h0: pwCyc = 16'(pcdld_pkg::PW0_CYC);
      2'h1: pwCyc = 16'(pcdld_pkg::PW1_CYC);
      2'h2: pwCyc = 16'(pcdld_pkg::PW2_CYC);
      2'h3: pwCyc = 16'(pcdld_pkg::PW3_CYC);
    endcase
    unique case (s_reg.cntCode)
      2'h0: cntTarget = 9'h001;
      2'h1: cntTarget = 9'h010;
      2'h2: cntTarget = 9'h040;
      2'h3: cntTarget = 9'h100;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    logic                        refEv;
    logic                        fbEv;
    logic                        cmp;
    logic                        ok;
    logic                        gained;
    logic                        lost;
    logic                        freqEv;
    logic                        busReq;
    logic                        fullWord;
    logic [2:0]                  irqClr;
    logic [pcdld_pkg::CNT_W-1:0] perDiff;
    logic [1:0]                  drv;
    refEv    = 1'b0;
    fbEv     = 1'b0;
    cmp      = 1'b0;
    ok       = 1'b0;
    gained   = 1'b0;
    lost     = 1'b0;
    freqEv   = 1'b0;
    irqClr   = 3'h0;
    perDiff  = '0;
    drv      = 2'h0;
    s_next   = s_reg;
    busReq   = wbCyc && wbStb && !s_reg.ack;
    fullWord = (wbSel == 4'hF);

    // Edge detection on the synchronous clock inputs.
    s_next.refPrev = refClkIn;
    s_next.fbPrev  = fbClkIn;

    if (refClkIn && !s_reg.refPrev) begin
      if (s_reg.refCnt >= s_reg.refDiv) begin
        s_next.refCnt = '0;
        refEv         = 1'b1;
      end else begin
        s_next.refCnt = s_reg.refCnt + 1'b1;
      end
    end

    // feedback divider; counts rising edges of fbClkIn up to fbDiv.
    if (fbClkIn && !s_reg.fbPrev) begin
      if (s_reg.fbCnt >= s_reg.fbDiv) begin
        s_next.fbCnt = '0;
        fbEv         = 1'b1;
      end else begin
        s_next.fbCnt = s_reg.fbCnt + 1'b1;
      end
    end

    // Period measurement of both detector inputs.
    s_next.refPerCnt = refEv ? 16'h0001 : satInc(s_reg.refPerCnt);
    s_next.fbPerCnt  = fbEv ? 16'h0001 : satInc(s_reg.fbPerCnt);
    if (refEv) begin
      s_next.refPer = s_reg.refPerCnt;
    end
    if (fbEv) begin
      s_next.fbPer = s_reg.fbPerCnt;
    end
    s_next.phaseCnt = satInc(s_reg.phaseCnt);

    if (s_reg.winCode == pcdld_pkg::WIN_FREQ) begin
      // a period gap of one pulse width is the smallest offset seen.
      if (fbEv) begin
        cmp     = 1'b1;
        perDiff = (s_reg.refPer >= s_reg.fbPer) ? s_reg.refPer - s_reg.fbPer
                                                : s_reg.fbPer - s_reg.refPer;
        ok      = perDiff < pwCyc;
      end
      s_next.pendRef = 1'b0;
      s_next.pendFb  = 1'b0;
    end else if (refEv && fbEv) begin
      // Coincident edges are a perfect phase match.
      cmp            = 1'b1;
      ok             = 1'b1;
      s_next.pendRef = 1'b0;
      s_next.pendFb  = 1'b0;
    end else if (refEv) begin
      if (s_reg.pendFb) begin
        cmp           = 1'b1;
        ok            = s_reg.phaseCnt <= winCyc;
        s_next.pendFb = 1'b0;
      end else begin
        // Two reference edges with no feedback edge between fail the check.
        cmp             = s_reg.pendRef;
        s_next.pendRef  = 1'b1;
        s_next.phaseCnt = 16'h0001;
      end
    end else if (fbEv) begin
      if (s_reg.pendRef) begin
        cmp            = 1'b1;
        ok             = s_reg.phaseCnt <= winCyc;
        s_next.pendRef = 1'b0;
      end else begin
        cmp             = s_reg.pendFb;
        s_next.pendFb   = 1'b1;
        s_next.phaseCnt = 16'h0001;
      end
    end

    // Lock qualification.
    if (cmp) begin
      s_next.inWin = ok;
      if (ok) begin
        if (s_reg.lockCnt != pcdld_pkg::LOCK_CNT_MAX) begin
          s_next.lockCnt = s_reg.lockCnt + 1'b1;
        end
        if (!s_reg.locked && (s_reg.lockCnt + 1'b1 >= cntTarget)) begin
          s_next.locked = 1'b1;
          gained        = 1'b1;
        end
      end else begin
        s_next.lockCnt = '0;
        s_next.locked  = 1'b0;
        lost           = s_reg.locked;
        freqEv         = (s_reg.winCode == pcdld_pkg::WIN_FREQ);
      end
    end

    // Register bus: one-cycle answer to every request.
    s_next.ack = busReq;
    if (busReq && wbWe) begin
      s_next.rdData = '0;
      if (fullWord) begin
        unique case (wbAdr)
          pcdld_pkg::ADDR_CFG0: begin
            s_next.refDiv = wbDatIn[pcdld_pkg::REF_DIV_W-1:0];
            s_next.fbDiv  = wbDatIn[pcdld_pkg::CFG0_FB_LSB +: pcdld_pkg::FB_DIV_W];
            s_next.refDly = wbDatIn[pcdld_pkg::CFG0_RDLY_LSB +: 3];
            s_next.fbDly  = wbDatIn[pcdld_pkg::CFG0_FDLY_LSB +: 3];
          end
          pcdld_pkg::ADDR_CFG1: begin
            s_next.pairSel = wbDatIn[pcdld_pkg::NUM_PAIRS-1:0];
            for (int i = 0; i < pcdld_pkg::NUM_PAIRS; i++) begin
              s_next.modeA[i] = wbDatIn[pcdld_pkg::CFG1_MODE_LSB + 4*i +: 2];
              s_next.modeB[i] = wbDatIn[pcdld_pkg::CFG1_MODE_LSB + 4*i + 2 +: 2];
            end
          end
          pcdld_pkg::ADDR_CFG2: begin
            s_next.pwCode   = wbDatIn[1:0];
            s_next.pumpCode = wbDatIn[pcdld_pkg::CFG2_PUMP_LSB +: 4];
          end
          pcdld_pkg::ADDR_CFG3: begin
            s_next.winCode = wbDatIn[1:0];
            s_next.cntCode = wbDatIn[pcdld_pkg::CFG3_CNT_LSB +: 2];
          end
          pcdld_pkg::ADDR_IRQ_STAT: irqClr = wbDatIn[2:0];
          pcdld_pkg::ADDR_IRQ_MASK: s_next.irqMask = wbDatIn[2:0];
          default: ;
        endcase
      end
    end else if (busReq) begin
      unique case (wbAdr)
        pcdld_pkg::ADDR_CFG0: begin
          s_next.rdData = {4'h0, s_reg.fbDly, s_reg.refDly, s_reg.fbDiv, s_reg.refDiv};
        end
        pcdld_pkg::ADDR_CFG1: s_next.rdData = {7'h00, s_reg.modeB[4], s_reg.modeA[4],
                                               s_reg.modeB[3], s_reg.modeA[3],
                                               s_reg.modeB[2], s_reg.modeA[2],
                                               s_reg.modeB[1], s_reg.modeA[1],
                                               s_reg.modeB[0], s_reg.modeA[0],
                                               s_reg.pairSel};
        pcdld_pkg::ADDR_CFG2:     s_next.rdData = {26'h0, s_reg.pumpCode, s_reg.pwCode};
        pcdld_pkg::ADDR_CFG3:     s_next.rdData = {28'h0, s_reg.cntCode, s_reg.winCode};
        pcdld_pkg::ADDR_STATUS:   s_next.rdData = {30'h0, s_reg.inWin, s_reg.locked};
        pcdld_pkg::ADDR_IRQ_STAT: s_next.rdData = {29'h0, s_reg.irqStat};
        pcdld_pkg::ADDR_IRQ_MASK: s_next.rdData = {29'h0, s_reg.irqMask};
        default:                  s_next.rdData = '0;
      endcase
    end

    // Sticky events; a new event wins over a clear in the same cycle.
    s_next.irqStat = (s_reg.irqStat & ~irqClr)
                   | {freqEv, lost, gained};
    s_next.irq     = |(s_next.irqStat & s_next.irqMask);

    // Output drivers for each pair.
    for (int i = 0; i < pcdld_pkg::NUM_PAIRS; i++) begin
      if (s_reg.pairSel[i]) begin
        // differential pair uses the A-half low bit only
        s_next.outA[i]    = vcoClkIn;
        s_next.outB[i]    = ~vcoClkIn;
        s_next.outAOeN[i] = s_reg.modeA[i][0];
        s_next.outBOeN[i] = s_reg.modeA[i][0];
      end else begin
        drv               = halfDrive(s_reg.modeA[i], vcoClkIn);
        s_next.outAOeN[i] = drv[1];
        s_next.outA[i]    = drv[0];
        drv               = halfDrive(s_reg.modeB[i], vcoClkIn);
        s_next.outBOeN[i] = drv[1];
        s_next.outB[i]    = drv[0];
      end
    end

    // delay offsets; reference delay lags, feedback delay leads.
    s_next.analog.refDelayPs    = pcdld_pkg::delayPs(s_reg.refDly);
    s_next.analog.fbDelayPs     = pcdld_pkg::delayPs(s_reg.fbDly);
    s_next.analog.pulseWidthPs  = pcdld_pkg::pulsePs(s_reg.pwCode);
    s_next.analog.pumpCurrentUa = pcdld_pkg::pumpUa(s_reg.pumpCode);
    s_next.analog.pumpHighZ     = (s_reg.pumpCode == 4'h0);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register with synchronous reset to the default settings.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_reg                      <= '0;
      s_reg.refDiv               <= pcdld_pkg::REF_DIV_RST;
      s_reg.fbDiv                <= pcdld_pkg::FB_DIV_RST;
      s_reg.pairSel              <= pcdld_pkg::PAIR_SEL_RST;
      s_reg.pwCode               <= pcdld_pkg::PW_RST;
      s_reg.pumpCode             <= pcdld_pkg::PUMP_RST;
      s_reg.winCode              <= pcdld_pkg::WIN_RST;
      s_reg.cntCode              <= pcdld_pkg::CNT_RST;
      s_reg.outAOeN              <= '1;
      s_reg.outBOeN              <= '1;
      s_reg.analog.pulseWidthPs  <= 13'(pcdld_pkg::PW0_PS);
      s_reg.analog.pumpCurrentUa <= pcdld_pkg::pumpUa(pcdld_pkg::PUMP_RST);
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register.
  assign wbDatOut     = s_reg.rdData;
  assign wbAck        = s_reg.ack;
  assign irq          = s_reg.irq;
  assign halfAOut     = s_reg.outA;
  assign halfAOeN     = s_reg.outAOeN;
  assign halfBOut     = s_reg.outB;
  assign halfBOeN     = s_reg.outBOeN;
  assign pllLock      = s_reg.locked;
  assign lockInWindow = s_reg.inWin;
  assign analogCfg    = s_reg.analog;

endmodule
`default_nettype wire

// [verif/pcdld_clk_src.sv]
`default_nettype none
module pcdld_clk_src (
  input  wire logic       mclk,
  input  wire logic       run,
  input  wire logic [1:0] skew,
  output var  logic       refClk,
  output wire logic       fbClk,
  output var  logic       vcoClk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] halfCnt = 2'h0;
  logic [2:0] refHist;
  // Reference toggles every four cycles while running and stands low when stopped.
  always_ff @(posedge mclk) begin
    halfCnt <= halfCnt + 2'h1;
    refClk <= run ? (halfCnt == 2'h3 ? ~refClk : refClk) : 1'b0;
    refHist <= {refHist[1:0], refClk};
    vcoClk <= run ? ~vcoClk : 1'b1; // Stopped oscillator rests high.
  end
  // feedback derived from the reference
  // Feedback is the reference delayed by skew cycles, far below the divider limit.
  assign fbClk = 1'({refHist, refClk} >> skew);
endmodule
`default_nettype wire

// [verif/pcdld_top_properties.sv]
`default_nettype none
module pcdld_top_properties (
  input wire logic                        mclk,
  input wire logic                        resetn,
  input wire logic                        wbCyc,
  input wire logic                        wbStb,
  input wire logic                        wbWe,
  input wire logic [31:0]                 wbDatOut,
  input wire logic                        wbAck,
  input wire logic                        irq,
  input wire logic [4:0]                  halfAOeN,
  input wire logic                        pllLock,
  input wire logic                        lockInWindow,
  input wire pcdld_pkg::pcdld_analog_type analogCfg
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Bus answers, reset state and decoded analog settings except the feedback delay stay within their tables.
  reset_quiet_a: assert property (disable iff (1'b0) !resetn |=>
    !wbAck && !irq && !pllLock && halfAOeN == 5'h1F) else $error("outputs active in reset");
  ack_answer_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("request not acknowledged");
  ack_pulse_a: assert property (wbAck |=> !wbAck) else $error("ack too long");
  write_rdata_a: assert property (wbAck && $past(wbWe) |-> wbDatOut == 32'h0)
    else $error("write returned data");
  pump_highz_a: assert property (analogCfg.pumpHighZ == (analogCfg.pumpCurrentUa == 12'h000))
    else $error("pump high impedance mismatch");
  pump_step_a: assert property (analogCfg.pumpCurrentUa % 12'h0C8 == 12'h000 &&
    analogCfg.pumpCurrentUa <= 12'hBB8) else $error("pump current off step");
  delay_table_a: assert property (analogCfg.refDelayPs inside {11'h000, 11'h0A0, 11'h140,
    11'h1E0, 11'h33E, 11'h46A, 11'h5AA, 11'h6D6}) else $error("delay value off table");
  pulse_table_a: assert property (analogCfg.pulseWidthPs inside {13'h5DC, 13'hBB8,
    13'h1194, 13'h1770}) else $error("pulse width off table");
  lock_window_a: assert property (pllLock |-> lockInWindow)
    else $error("lock held after failed comparison");
endmodule
bind pcdld_top pcdld_top_properties prop_u (.mclk(mclk), .resetn(resetn), .wbCyc(wbCyc),
  .wbStb(wbStb), .wbWe(wbWe), .wbDatOut(wbDatOut), .wbAck(wbAck), .irq(irq),
  .halfAOeN(halfAOeN), .pllLock(pllLock), .lockInWindow(lockInWindow), .analogCfg(analogCfg));
`default_nettype wire

// [verif/pcdld_top_tb.sv]
`default_nettype none
module pcdld_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, resetn, wbCyc, wbStb, wbWe, wbAck, irq, run;
  logic        refClk, fbClk, vcoClk, pllLock, inWin;
  logic [7:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [1:0]  skew;
  logic [31:0] wbDatIn, wbDatOut, rd;
  logic [4:0]  aOut, aOeN, bOut, bOeN;
  logic [10:0] dlyPs [8] = '{11'h000, 11'h0A0, 11'h140, 11'h1E0, 11'h33E, 11'h46A,
                             11'h5AA, 11'h6D6};
  pcdld_pkg::pcdld_analog_type ana;
  int nFail = 0, nCompared = 0, n;
  pcdld_top dut_u (.mclk(mclk), .resetn(resetn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
    .irq(irq), .refClkIn(refClk), .fbClkIn(fbClk), .vcoClkIn(vcoClk), .halfAOut(aOut),
    .halfAOeN(aOeN), .halfBOut(bOut), .halfBOeN(bOeN), .pllLock(pllLock),
    .lockInWindow(inWin), .analogCfg(ana));
  pcdld_clk_src src_u (.mclk(mclk), .run(run), .skew(skew), .refClk(refClk), .fbClk(fbClk),
    .vcoClk(vcoClk));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Comparison, verdict and one classic Wishbone cycle.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      nFail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] a, input logic we, input logic [31:0] d,
                      input logic [3:0] s);
    int k;
    k = 0;
    @(posedge mclk);
    {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatIn} <= {2'h3, we, a, s, d};
    do begin
      @(posedge mclk);
      k++;
    end while (wbAck !== 1'b1);
    check(32'(k), 32'h2); // answer one cycle after the taking edge.
    rd = wbDatOut;
    {wbCyc, wbStb} <= 2'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, 4'hF);
    repeat (2) @(posedge mclk); // Decoded outputs are registered after the word lands.
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0, 4'hF);
    check(rd, exp);
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    nFail++;
    conclude();
  end
  // Main sequence: defaults, field decoding, output modes, then lock behaviour.
  initial begin
    {resetn, wbCyc, wbStb, wbWe, run, skew, wbAdr, wbSel, wbDatIn} <= '0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    check(32'(ana.pulseWidthPs), 32'h5DC);
    check(32'(ana.pumpCurrentUa), 32'h7D0);
    rdChk(pcdld_pkg::ADDR_CFG0, 32'h0001FC7F);
    rdChk(pcdld_pkg::ADDR_CFG1, 32'h1F);
    rdChk(pcdld_pkg::ADDR_CFG2, 32'h28);
    rdChk(pcdld_pkg::ADDR_CFG3, 32'h9);
    rdChk(8'h1C, 32'h0);
    for (int c = 0; c < 16; c++) begin
      wr(pcdld_pkg::ADDR_CFG2, 32'(c * 4 + c % 4));
      check(32'(ana.pumpCurrentUa), 32'(c * 32'h0C8));
      check(32'(ana.pumpHighZ), 32'(c == 0));
      check(32'(ana.pulseWidthPs), 32'((c % 4 + 1) * 32'h5DC));
    end
    xfer(pcdld_pkg::ADDR_CFG2, 1'b1, 32'h0, 4'h3);
    rdChk(pcdld_pkg::ADDR_CFG2, 32'h3F);
    for (int i = 0; i < 8; i++) begin
      wr(pcdld_pkg::ADDR_CFG0, (32'(i) << 22) | (32'(7 - i) << 25));
      check(32'(ana.refDelayPs), 32'(dlyPs[i]));
      check(32'(ana.fbDelayPs), 32'(dlyPs[7 - i]));
    end
    for (int m = 0; m < 4; m++) begin
      wr(pcdld_pkg::ADDR_CFG1, 32'(m * 5) * 32'h111110 * 2);
      check(32'({aOeN, bOeN}), m == 1 ? 32'h3FF : 32'h0);
      if (m != 1) check(32'({aOut, bOut}), m == 0 ? 32'h3FF : 32'h0);
    end
    wr(pcdld_pkg::ADDR_CFG1, 32'h1DDDDDDF);
    check(32'({aOut, aOeN, bOut, bOeN}), 32'hF8000);
    wr(pcdld_pkg::ADDR_CFG1, 32'h0022223F);
    check(32'({aOeN, bOeN}), 32'h3FF);
    wr(pcdld_pkg::ADDR_IRQ_MASK, 32'h7);
    wr(pcdld_pkg::ADDR_CFG3, 32'h1);
    run <= 1'b1;
    n = 0;
    while (pllLock !== 1'b1 && n++ < 200) @(posedge mclk);
    check(32'({pllLock, irq}), 32'h3);
    rdChk(pcdld_pkg::ADDR_IRQ_STAT, 32'h1);
    wr(pcdld_pkg::ADDR_IRQ_STAT, 32'h1);
    rdChk(pcdld_pkg::ADDR_IRQ_STAT, 32'h0);
    check(32'(irq), 32'h0);
    skew <= 2'h2;
    n = 0;
    while (pllLock !== 1'b0 && n++ < 12) @(posedge mclk);
    check(32'({pllLock, inWin}), 32'h0);
    rdChk(pcdld_pkg::ADDR_IRQ_STAT, 32'h2);
    wr(pcdld_pkg::ADDR_CFG3, 32'h5);
    @(posedge refClk);
    skew <= 2'h0;
    n = 0;
    while (pllLock !== 1'b1 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    check(32'(n >= 118 && n <= 126), 32'h1);
    // Frequency mode: equal divided rates keep the lock, a rate gap drops it.
    wr(pcdld_pkg::ADDR_CFG3, 32'h3);
    wr(pcdld_pkg::ADDR_CFG0, 32'h401);
    repeat (60) @(posedge mclk);
    check(32'({pllLock, inWin}), 32'h3);
    wr(pcdld_pkg::ADDR_CFG0, 32'h1);
    repeat (60) @(posedge mclk);
    check(32'({pllLock, inWin}), 32'h0);
    rdChk(pcdld_pkg::ADDR_IRQ_STAT, 32'h7);
    // A reset in mid-run restores every default and clears the lock state.
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rdChk(pcdld_pkg::ADDR_CFG0, 32'h0001FC7F);
    check(32'({pllLock, irq, inWin}), 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
